//--- generator_and_repetition_control_test.sv
`timescale 1ns/1ps
`include "grc_params.svh"
module generator_and_repetition_control_test;
  import grc_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  grc_cmd_s cmd;
  grc_rep_cfg_s cfg = '0;
  logic [`GRC_GEN_N-1:0] avail = '0;
  logic conn = 1'b0;
  logic app = 1'b0;
  logic eval = 1'b0;
  logic busy;
  grc_rsp_s rsp;
  grc_gen_e [`GRC_GEN_N-1:0] gst;
  logic [`GRC_GEN_N-1:0] claim;
  grc_meas_e mst;
  logic [`GRC_CNT_W-1:0] pcnt;
  logic rvalid, rupd, ev, aerr;
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;
  grc_rsp_s r;
  logic seen, bsy;
  grc_rep_e m;
  logic [13:0] c;

  always #50 sys_clk_i = ~sys_clk_i;

  grc_top DUT (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd), .rep_cfg_i(cfg), .res_avail_i(avail),
    .audio_uses_conn_i(conn), .app_sel_i(app), .eval_done_i(eval), .busy_o(busy), .rsp_o(rsp),
    .gen_status_o(gst), .res_claim_o(claim), .meas_state_o(mst), .period_cnt_o(pcnt),
    .results_valid_o(rvalid), .result_upd_o(rupd), .event_o(ev), .app_err_o(aerr));

  grc_host_model host (.clk_i(sys_clk_i), .busy_i(busy), .rsp_i(rsp), .cmd_o(cmd));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // a full run takes a few hundred cycles
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic check(input string name, input logic [19:0] exp, input logic [19:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic send(input grc_op_e op, input logic tgt);
    host.issue(op, tgt, r, seen, bsy);
    check("answer", 20'h1, {19'h0, seen});
  endtask

  task automatic pulse;
    @(posedge sys_clk_i);
    #1 eval = 1'b1;
    @(posedge sys_clk_i);
    #1 eval = 1'b0;
  endtask

  // count 0 counts as one period
  function automatic grc_meas_e exp_meas(grc_rep_e md, logic [13:0] cn, int n);
    int lim;
    lim = (md == GRC_REP_ONE_PERIOD_MODE || cn == 14'h0) ? 1 : int'(cn);
    if (md != GRC_REP_CONTINUOUS && n >= lim) return GRC_MEAS_RDY;
    return GRC_MEAS_RUN;
  endfunction

  task automatic run_meas(input grc_rep_e md, input logic [13:0] cn, input int np);
    int n;
    logic was;
    grc_meas_e e;
    n = 0;
    cfg = '{mode: md, count: cn, step_en: 1'b0};
    send(GRC_OP_MEAS_INIT, 1'b0);
    check("init", GRC_MEAS_RUN, mst);
    for (int i = 0; i < np; i++) begin
      was = (mst === GRC_MEAS_RUN);
      pulse();
      if (was) n++;
      e = exp_meas(md, cn, n);
      check("state", e, mst);
      check("periods", n[19:0], pcnt);
      check("update", was, rupd);
      check("event", was && e == GRC_MEAS_RDY, ev);
      check("valid", 1'b1, rvalid);
    end
    send(GRC_OP_MEAS_ABORT, 1'b0);
    check("aborted", {GRC_MEAS_OFF, 1'b0}, {mst, rvalid});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h023d8bd1));
    repeat (8) @(posedge sys_clk_i);
    #1 rst_n_i = 1'b1;
    repeat (2) @(posedge sys_clk_i);
    #1;
    check("reset", {GRC_GEN_OFF, GRC_GEN_OFF, GRC_MEAS_OFF, 1'b0}, {gst[1], gst[0], mst, busy});
    $display("test reset done");

    avail = 2'b11;
    conn = 1'b1;
    send(GRC_OP_GEN_START, 1'b0);
    check("start busy", 1'b1, bsy);
    check("start rsp", {1'b0, GRC_GEN_RUN}, {r.err, r.gen_status});
    check("radio", {GRC_GEN_RUN, 1'b1}, {gst[0], claim[0]});
    send(GRC_OP_GEN_START, 1'b0);
    check("restart", {1'b0, GRC_GEN_RUN, 1'b1}, {r.err, gst[0], claim[0]});
    send(GRC_OP_GEN_START, 1'b1);
    check("conflict code", `GRC_ERR_INIT_IGNORED, r.err_code);
    check("conflict", {1'b1, GRC_GEN_ERR, 1'b0}, {r.err, gst[1], claim[1]});
    send(GRC_OP_GEN_QUERY, 1'b1);
    check("query err", GRC_GEN_ERR, r.gen_status);
    send(GRC_OP_GEN_ABORT, 1'b0);
    check("abort", {1'b1, GRC_GEN_OFF, 1'b0}, {bsy, gst[0], claim[0]});
    send(GRC_OP_GEN_ABORT, 1'b0);
    check("abort off", {1'b0, GRC_GEN_OFF}, {r.err, gst[0]});
    send(GRC_OP_GEN_START, 1'b1);
    check("audio", {GRC_GEN_RUN, 1'b1}, {gst[1], claim[1]});
    // audio off the connector: both may run together
    conn = 1'b0;
    send(GRC_OP_GEN_START, 1'b0);
    check("shared", {GRC_GEN_RUN, GRC_GEN_RUN}, {gst[0], gst[1]});
    send(GRC_OP_GEN_ABORT, 1'b0);
    send(GRC_OP_GEN_ABORT, 1'b1);
    avail = 2'b10;
    send(GRC_OP_GEN_START, 1'b0);
    check("no resource", {1'b1, GRC_GEN_ERR, 1'b0}, {r.err, r.gen_status, claim[0]});
    send(GRC_OP_GEN_ABORT, 1'b0);
    send(GRC_OP_GEN_QUERY, 1'b0);
    check("query off", GRC_GEN_OFF, r.gen_status);
    $display("test generators done");

    avail = 2'b11;
    for (int k = 0; k < 6; k++) begin
      m = grc_rep_e'(2'($urandom_range(2, 0)));
      c = 14'($urandom_range(4, 0));
      run_meas(m, c, $urandom_range(5, 1));
    end
    run_meas(GRC_REP_COUNTING, 14'h0001, 2);
    run_meas(GRC_REP_ONE_PERIOD_MODE, 14'h0003, 2);
    run_meas(GRC_REP_CONTINUOUS, 14'h0000, 4);
    $display("test repetition done");

    cfg = '{mode: GRC_REP_COUNTING, count: 14'h0003, step_en: 1'b1};
    send(GRC_OP_MEAS_INIT, 1'b0);
    pulse();
    check("step", {GRC_MEAS_STEP, 1'b1}, {mst, ev});
    send(GRC_OP_MEAS_CONT, 1'b0);
    check("continue", GRC_MEAS_RUN, mst);
    send(GRC_OP_MEAS_CONT, 1'b0);
    check("cont in run", {1'b1, `GRC_ERR_SETTINGS_CONFLICT}, {r.err, r.err_code});
    pulse();
    check("step again", {GRC_MEAS_STEP, 14'h0002}, {mst, pcnt});
    send(GRC_OP_MEAS_STOP, 1'b0);
    check("stop", {1'b0, GRC_MEAS_HALT}, {r.err, mst});
    send(GRC_OP_MEAS_ABORT, 1'b0);
    send(GRC_OP_MEAS_STOP, 1'b0);
    check("stop off", {1'b1, `GRC_ERR_SETTINGS_CONFLICT}, {r.err, r.err_code});
    // stop in run waits for the period end, so the pulse runs beside the request
    cfg = '{mode: GRC_REP_CONTINUOUS, count: 14'h0000, step_en: 1'b0};
    send(GRC_OP_MEAS_INIT, 1'b0);
    fork
      send(GRC_OP_MEAS_STOP, 1'b0);
      begin
        repeat (3) @(posedge sys_clk_i);
        pulse();
      end
    join
    check("stop run", {1'b1, 1'b0, GRC_MEAS_HALT, 1'b0}, {bsy, r.err, mst, ev});
    send(GRC_OP_MEAS_ABORT, 1'b0);
    $display("test stepping done");

    send(GRC_OP_GEN_START, 1'b0);
    cfg = '{mode: GRC_REP_CONTINUOUS, count: 14'h0000, step_en: 1'b0};
    send(GRC_OP_MEAS_INIT, 1'b0);
    app = 1'b1;
    repeat (3) @(posedge sys_clk_i);
    #1;
    check("app change", {GRC_MEAS_HALT, 1'b1}, {mst, aerr});
    send(GRC_OP_GEN_ABORT, 1'b0);
    send(GRC_OP_MEAS_INIT, 1'b0);
    check("app clear", {GRC_MEAS_RUN, 1'b0}, {mst, aerr});
    send(GRC_OP_MEAS_ABORT, 1'b0);
    $display("test application done");
    tally_and_finish();
  end
endmodule

//--- grc_gen_fsm.sv
`timescale 1ns/1ps
`include "grc_params.svh"

module grc_gen_fsm #(
  parameter int SETTLE_CYC = `GRC_SETTLE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic grant_i,
  output grc_pkg::grc_gen_e state_o,
  output logic claim_o,
  output logic done_o,
  output logic fail_o
);
  import grc_pkg::*;

  localparam int CW = $clog2(SETTLE_CYC + 1);
  localparam int LAT = SETTLE_CYC + 1;

  grc_gen_e state_q;
  logic claim_q;
  logic done_q;
  logic fail_q;
  logic fail_pend_q;
  logic [CW-1:0] cnt_q;
  logic start_ok;
  logic start_bad;
  logic abort_ok;

  assign start_ok = start_i && state_q != GRC_GEN_RUN && grant_i;
  assign start_bad = start_i && state_q != GRC_GEN_RUN && !grant_i;
  assign abort_ok = abort_i && state_q == GRC_GEN_RUN;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= GRC_GEN_OFF;
      claim_q <= 1'b0;
    end else if (start_ok) begin
      state_q <= GRC_GEN_RUN;
      claim_q <= 1'b1;
    end else if (start_bad) begin
      state_q <= GRC_GEN_ERR;
      claim_q <= 1'b0;
    end else if (abort_i && state_q != GRC_GEN_OFF) begin
      state_q <= GRC_GEN_OFF;
      claim_q <= 1'b0;
    end
  end

  // switching finishes one cycle after the settle time; ignored or refused commands finish two cycles after the command
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else if (start_i || abort_i) begin
      cnt_q <= (start_ok || abort_ok) ? CW'(SETTLE_CYC) : CW'(1);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - CW'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_q <= 1'b0;
      fail_q <= 1'b0;
      fail_pend_q <= 1'b0;
    end else begin
      done_q <= cnt_q == CW'(1);
      fail_q <= cnt_q == CW'(1) && fail_pend_q;
      if (start_bad) begin
        fail_pend_q <= 1'b1;
      end else if (cnt_q == CW'(1)) begin
        fail_pend_q <= 1'b0;
      end
    end
  end

  assign state_o = state_q;
  assign claim_o = claim_q;
  assign done_o = done_q;
  assign fail_o = fail_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_start_run;
    start_i && state_q == GRC_GEN_OFF && grant_i |=> state_q == GRC_GEN_RUN && claim_q;
  endproperty
  a_start_run: assert property (p_start_run) else $error("start did not reach run");

  property p_start_idle;
    start_i && state_q == GRC_GEN_RUN && !abort_i |=> state_q == GRC_GEN_RUN && $stable(claim_q);
  endproperty
  a_start_idle: assert property (p_start_idle) else $error("start changed a running generator");

  property p_start_fail;
    start_bad |=> state_q == GRC_GEN_ERR && !claim_q ##1 fail_q && done_q;
  endproperty
  a_start_fail: assert property (p_start_fail) else $error("refused start not reported");

  property p_start_seq;
    start_ok |=> !done_q [*2] ##(LAT - 2) done_q;
  endproperty
  a_start_seq: assert property (p_start_seq) else $error("start completion mistimed");

  property p_abort_off;
    abort_ok |=> state_q == GRC_GEN_OFF && !claim_q;
  endproperty
  a_abort_off: assert property (p_abort_off) else $error("abort left generator on");

  property p_abort_idle;
    abort_i && state_q == GRC_GEN_OFF && !start_i |=> state_q == GRC_GEN_OFF;
  endproperty
  a_abort_idle: assert property (p_abort_idle) else $error("abort changed an off generator");

  property p_abort_seq;
    abort_ok |-> ##LAT done_q && state_q == GRC_GEN_OFF;
  endproperty
  a_abort_seq: assert property (p_abort_seq) else $error("abort completion mistimed");

  property p_state_cause;
    $changed(state_q) |-> $past(start_i || abort_i);
  endproperty
  a_state_cause: assert property (p_state_cause) else $error("state moved without a command");

  c_gen_fail: cover property (start_bad ##2 fail_q);
endmodule

//--- grc_host_model.sv
`timescale 1ns/1ps
module grc_host_model (
  input wire logic clk_i,
  input wire logic busy_i,
  input grc_pkg::grc_rsp_s rsp_i,
  output grc_pkg::grc_cmd_s cmd_o
);
  import grc_pkg::*;

  initial cmd_o = '0;

  // one request at a time; anything sent while busy would be dropped silently
  task automatic issue(input grc_op_e op, input logic tgt, output grc_rsp_s rsp, output logic seen,
    output logic busy_taken);
    int n;
    n = 0;
    seen = 1'b0;
    rsp = '0;
    @(posedge clk_i);
    #1;
    while (busy_i !== 1'b0 && n < 50) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    cmd_o = '{valid: 1'b1, op: op, target: tgt};
    @(posedge clk_i);
    #1;
    cmd_o = '0;
    busy_taken = busy_i;
    // answer stands one cycle only; looked at just after each edge, never on it
    for (n = 0; n < 40 && !seen; n++) begin
      if (rsp_i.valid === 1'b1) begin
        seen = 1'b1;
        rsp = rsp_i;
      end else begin
        @(posedge clk_i);
        #1;
      end
    end
  endtask
endmodule

//--- grc_params.svh
`ifndef GRC_PARAMS_SVH
`define GRC_PARAMS_SVH

// clock and generator switching time
`define GRC_CLK_PERIOD_NS 100
`define GRC_SETTLE_NS 500
`define GRC_SETTLE_CYC ((`GRC_SETTLE_NS + `GRC_CLK_PERIOD_NS - 1) / `GRC_CLK_PERIOD_NS)

// repetition counting
`define GRC_CNT_W 14
`define GRC_CNT_ZERO 14'h0000
`define GRC_CNT_ONE 14'h0001
`define GRC_CNT_MAX 14'h2710

// error codes, two's complement
`define GRC_ERR_W 16
`define GRC_ERR_NONE 16'h0000
`define GRC_ERR_INIT_IGNORED 16'hff2b
`define GRC_ERR_SETTINGS_CONFLICT 16'hff23

// generator slots
`define GRC_GEN_N 2
`define GRC_RADIO 1'b0
`define GRC_AUDIO 1'b1

`define GRC_RST_SYNC_INIT 2'b00

`endif

//--- grc_pkg.sv
`include "grc_params.svh"

package grc_pkg;

  typedef enum logic [1:0] {
    GRC_GEN_OFF = 2'h0,
    GRC_GEN_RUN = 2'h1,
    GRC_GEN_ERR = 2'h2
  } grc_gen_e;

  typedef enum logic [2:0] {
    GRC_OP_NONE = 3'h0,
    GRC_OP_GEN_START = 3'h1,
    GRC_OP_GEN_ABORT = 3'h2,
    GRC_OP_GEN_QUERY = 3'h3,
    GRC_OP_MEAS_INIT = 3'h4,
    GRC_OP_MEAS_STOP = 3'h5,
    GRC_OP_MEAS_ABORT = 3'h6,
    GRC_OP_MEAS_CONT = 3'h7
  } grc_op_e;

  typedef enum logic [1:0] {
    GRC_REP_ONE_PERIOD_MODE = 2'h0,
    GRC_REP_CONTINUOUS = 2'h1,
    GRC_REP_COUNTING = 2'h2
  } grc_rep_e;

  typedef enum logic [2:0] {
    GRC_MEAS_OFF = 3'h0,
    GRC_MEAS_RUN = 3'h1,
    GRC_MEAS_STEP = 3'h3,
    GRC_MEAS_RDY = 3'h2,
    GRC_MEAS_HALT = 3'h6
  } grc_meas_e;

  typedef struct packed {
    logic valid;
    grc_op_e op;
    logic target;
  } grc_cmd_s;

  typedef struct packed {
    grc_rep_e mode;
    logic [`GRC_CNT_W-1:0] count;
    logic step_en;
  } grc_rep_cfg_s;

  typedef struct packed {
    logic valid;
    logic err;
    logic [`GRC_ERR_W-1:0] err_code;
    grc_gen_e gen_status;
  } grc_rsp_s;

endpackage

//--- grc_top.sv
`timescale 1ns/1ps
`include "grc_params.svh"

module grc_top (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input grc_pkg::grc_cmd_s cmd_i,
  input grc_pkg::grc_rep_cfg_s rep_cfg_i,
  input wire logic [`GRC_GEN_N-1:0] res_avail_i,
  input wire logic audio_uses_conn_i,
  input wire logic app_sel_i,
  input wire logic eval_done_i,
  output logic busy_o,
  output grc_pkg::grc_rsp_s rsp_o,
  output grc_pkg::grc_gen_e [`GRC_GEN_N-1:0] gen_status_o,
  output logic [`GRC_GEN_N-1:0] res_claim_o,
  output grc_pkg::grc_meas_e meas_state_o,
  output logic [`GRC_CNT_W-1:0] period_cnt_o,
  output logic results_valid_o,
  output logic result_upd_o,
  output logic event_o,
  output logic app_err_o
);
  import grc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= `GRC_RST_SYNC_INIT;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // command intake and generators

  logic take;
  logic [`GRC_GEN_N-1:0] needs_conn;
  logic [`GRC_GEN_N-1:0] gen_start;
  logic [`GRC_GEN_N-1:0] gen_abort;
  logic [`GRC_GEN_N-1:0] gen_grant;
  logic [`GRC_GEN_N-1:0] gen_done;
  logic [`GRC_GEN_N-1:0] gen_fail;
  logic [`GRC_GEN_N-1:0] gen_claim;
  grc_gen_e [`GRC_GEN_N-1:0] gen_state;

  // commands are refused while a sequential one is still in flight
  assign take = cmd_i.valid && !busy_o;
  assign needs_conn = {audio_uses_conn_i, 1'b1};

  for (genvar g = 0; g < `GRC_GEN_N; g++) begin : g_gen
    localparam int OTHER = `GRC_GEN_N - 1 - g;
    assign gen_start[g] = take && cmd_i.op == GRC_OP_GEN_START && cmd_i.target == 1'(g);
    assign gen_abort[g] = take && cmd_i.op == GRC_OP_GEN_ABORT && cmd_i.target == 1'(g);
    // connector owned by the other slot makes this start fail when this slot needs the connector too
    assign gen_grant[g] = res_avail_i[g] && !(needs_conn[g] && needs_conn[OTHER] && gen_claim[OTHER]);

    grc_gen_fsm #(
      .SETTLE_CYC(`GRC_SETTLE_CYC)
    ) u_gen (
      .clk_i(sys_clk_i),
      .rst_n_i(rst_n),
      .start_i(gen_start[g]),
      .abort_i(gen_abort[g]),
      .grant_i(gen_grant[g]),
      .state_o(gen_state[g]),
      .claim_o(gen_claim[g]),
      .done_o(gen_done[g]),
      .fail_o(gen_fail[g])
    );
  end

  assign gen_status_o = gen_state;
  assign res_claim_o = gen_claim;

  ////////////////////////////////////////////////////////////////////////////
  // measurement repetition control

  grc_meas_e meas_q;
  grc_rep_e mode_q;
  logic step_q;
  logic [`GRC_CNT_W-1:0] lim_q;
  logic [`GRC_CNT_W-1:0] cnt_q;
  logic stop_pend_q;
  logic app_q;
  logic app_err_q;
  logic valid_q;
  logic upd_q;
  logic event_q;
  logic period_end;
  logic last_period;
  logic halt_req;
  logic app_hit;
  logic meas_live;
  logic op_init;
  logic op_stop;
  logic op_abort;
  logic op_cont;
  logic cont_ok;
  logic [`GRC_CNT_W-1:0] lim_d;

  assign op_init = take && cmd_i.op == GRC_OP_MEAS_INIT;
  assign op_stop = take && cmd_i.op == GRC_OP_MEAS_STOP;
  assign op_abort = take && cmd_i.op == GRC_OP_MEAS_ABORT;
  assign op_cont = take && cmd_i.op == GRC_OP_MEAS_CONT;
  assign meas_live = meas_q == GRC_MEAS_RUN || meas_q == GRC_MEAS_STEP;
  assign cont_ok = meas_q == GRC_MEAS_STEP || meas_q == GRC_MEAS_HALT || meas_q == GRC_MEAS_RDY;
  assign period_end = meas_q == GRC_MEAS_RUN && eval_done_i;
  assign last_period = mode_q == GRC_REP_ONE_PERIOD_MODE ||
                       (mode_q == GRC_REP_COUNTING && cnt_q + `GRC_CNT_ONE >= lim_q);
  assign halt_req = stop_pend_q || (op_stop && meas_q == GRC_MEAS_RUN);
  assign app_hit = app_sel_i != app_q && (gen_claim != '0) && meas_live;

  // out of range counts are clamped rather than refused
  assign lim_d = rep_cfg_i.count == `GRC_CNT_ZERO ? `GRC_CNT_ONE :
                 rep_cfg_i.count > `GRC_CNT_MAX ? `GRC_CNT_MAX : rep_cfg_i.count;

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= GRC_REP_ONE_PERIOD_MODE;
      step_q <= 1'b0;
      lim_q <= `GRC_CNT_ONE;
    end else if (op_init) begin
      mode_q <= rep_cfg_i.mode;
      step_q <= rep_cfg_i.step_en;
      lim_q <= lim_d;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      meas_q <= GRC_MEAS_OFF;
    end else if (op_abort) begin
      meas_q <= GRC_MEAS_OFF;
    end else if (app_hit) begin
      meas_q <= GRC_MEAS_HALT;
    end else if (op_init || (op_cont && cont_ok)) begin
      meas_q <= GRC_MEAS_RUN;
    end else if (op_stop && meas_q == GRC_MEAS_STEP) begin
      meas_q <= GRC_MEAS_HALT;
    end else if (period_end) begin
      if (halt_req) begin
        meas_q <= GRC_MEAS_HALT;
      end else if (last_period) begin
        meas_q <= GRC_MEAS_RDY;
      end else if (step_q) begin
        meas_q <= GRC_MEAS_STEP;
      end else begin
        meas_q <= GRC_MEAS_RUN;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      stop_pend_q <= 1'b0;
    end else if (op_stop && meas_q == GRC_MEAS_RUN) begin
      stop_pend_q <= 1'b1;
    end else if (meas_q != GRC_MEAS_RUN) begin
      stop_pend_q <= 1'b0;
    end
  end

  // period counter restarts on init and on continue after a finished run
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= `GRC_CNT_ZERO;
    end else if (op_init || (op_cont && meas_q == GRC_MEAS_RDY)) begin
      cnt_q <= `GRC_CNT_ZERO;
    end else if (period_end && cnt_q != `GRC_CNT_MAX) begin
      cnt_q <= cnt_q + `GRC_CNT_ONE;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      valid_q <= 1'b0;
      upd_q <= 1'b0;
      event_q <= 1'b0;
    end else begin
      upd_q <= period_end && !op_abort && !app_hit;
      event_q <= period_end && !op_abort && !app_hit && !halt_req && (last_period || step_q);
      if (op_abort || op_init) begin
        valid_q <= 1'b0;
      end else if (period_end) begin
        valid_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      app_q <= 1'b0;
      app_err_q <= 1'b0;
    end else begin
      app_q <= app_sel_i;
      if (app_hit) begin
        app_err_q <= 1'b1;
      end else if (op_init) begin
        app_err_q <= 1'b0;
      end
    end
  end

  assign meas_state_o = meas_q;
  assign period_cnt_o = cnt_q;
  assign results_valid_o = valid_q;
  assign result_upd_o = upd_q;
  assign event_o = event_q;
  assign app_err_o = app_err_q;

  ////////////////////////////////////////////////////////////////////////////
  // answers

  grc_rsp_s rsp_q;
  logic busy_q;
  logic stop_resolve;
  logic gen_fin;

  assign stop_resolve = stop_pend_q && meas_q != GRC_MEAS_RUN;
  assign gen_fin = gen_done != '0;

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
    end else if (take && (cmd_i.op == GRC_OP_GEN_START || cmd_i.op == GRC_OP_GEN_ABORT || halt_req)) begin
      busy_q <= 1'b1;
    end else if (gen_fin || stop_resolve) begin
      busy_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= '0;
      if (gen_fin) begin
        rsp_q.valid <= 1'b1;
        rsp_q.err <= gen_fail != '0;
        rsp_q.err_code <= gen_fail != '0 ? `GRC_ERR_INIT_IGNORED : `GRC_ERR_NONE;
        rsp_q.gen_status <= gen_done[`GRC_AUDIO] ? gen_state[`GRC_AUDIO] : gen_state[`GRC_RADIO];
      end else if (stop_resolve) begin
        rsp_q.valid <= 1'b1;
      end else if (take) begin
        unique case (cmd_i.op)
          GRC_OP_GEN_QUERY: begin
            rsp_q.valid <= 1'b1;
            rsp_q.gen_status <= gen_state[cmd_i.target];
          end
          GRC_OP_MEAS_INIT, GRC_OP_MEAS_ABORT: begin
            rsp_q.valid <= 1'b1;
          end
          GRC_OP_MEAS_STOP: begin
            if (meas_q == GRC_MEAS_STEP) begin
              rsp_q.valid <= 1'b1;
            end else if (meas_q != GRC_MEAS_RUN) begin
              rsp_q.valid <= 1'b1;
              rsp_q.err <= 1'b1;
              rsp_q.err_code <= `GRC_ERR_SETTINGS_CONFLICT;
            end
          end
          GRC_OP_MEAS_CONT: begin
            rsp_q.valid <= 1'b1;
            rsp_q.err <= !cont_ok;
            rsp_q.err_code <= cont_ok ? `GRC_ERR_NONE : `GRC_ERR_SETTINGS_CONFLICT;
          end
          GRC_OP_NONE, GRC_OP_GEN_START, GRC_OP_GEN_ABORT: begin
          end
        endcase
      end
    end
  end

  assign busy_o = busy_q;
  assign rsp_o = rsp_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n);

  logic quiet;
  assign quiet = !take && !app_hit;

  property p_conn_conflict;
    gen_start[`GRC_AUDIO] && audio_uses_conn_i && gen_claim[`GRC_RADIO] &&
      gen_state[`GRC_AUDIO] != GRC_GEN_RUN |=> gen_state[`GRC_AUDIO] == GRC_GEN_ERR;
  endproperty
  a_conn_conflict: assert property (p_conn_conflict) else $error("connector conflict not refused");

  property p_fail_code;
    gen_fail != '0 |=> rsp_q.valid && rsp_q.err && rsp_q.err_code == `GRC_ERR_INIT_IGNORED;
  endproperty
  a_fail_code: assert property (p_fail_code) else $error("refused start gave wrong code");

  property p_query;
    take && cmd_i.op == GRC_OP_GEN_QUERY |=> rsp_q.valid &&
      rsp_q.gen_status inside {GRC_GEN_OFF, GRC_GEN_RUN, GRC_GEN_ERR};
  endproperty
  a_query: assert property (p_query) else $error("status query answer illegal");

  property p_app_halt;
    app_hit && !op_abort |=> meas_q == GRC_MEAS_HALT && app_err_q;
  endproperty
  a_app_halt: assert property (p_app_halt) else $error("application change did not halt");

  property p_run_holds;
    meas_q == GRC_MEAS_RUN && !eval_done_i && quiet |=> meas_q == GRC_MEAS_RUN;
  endproperty
  a_run_holds: assert property (p_run_holds) else $error("run left without cause");

  property p_one_period;
    period_end && quiet && !halt_req && mode_q == GRC_REP_ONE_PERIOD_MODE |=>
      meas_q == GRC_MEAS_RDY && event_q && valid_q;
  endproperty
  a_one_period: assert property (p_one_period) else $error("one period mode did not finish");

  property p_continuous;
    period_end && quiet && !halt_req && !step_q && mode_q == GRC_REP_CONTINUOUS |=>
      meas_q == GRC_MEAS_RUN && valid_q && upd_q && !event_q;
  endproperty
  a_continuous: assert property (p_continuous) else $error("continuous mode stopped");

  property p_count_end;
    period_end && quiet && !halt_req && mode_q == GRC_REP_COUNTING && cnt_q + `GRC_CNT_ONE == lim_q |=>
      meas_q == GRC_MEAS_RDY && cnt_q == lim_q;
  endproperty
  a_count_end: assert property (p_count_end) else $error("counting mode miscounted");

  property p_step;
    period_end && quiet && !halt_req && step_q && !last_period |=> meas_q == GRC_MEAS_STEP && event_q;
  endproperty
  a_step: assert property (p_step) else $error("stepping did not pause");

  property p_resume;
    op_cont && meas_q == GRC_MEAS_STEP && !app_hit |=> meas_q == GRC_MEAS_RUN;
  endproperty
  a_resume: assert property (p_resume) else $error("continue did not resume");

  c_count_rdy: cover property (mode_q == GRC_REP_COUNTING && meas_q == GRC_MEAS_RUN ##1 meas_q == GRC_MEAS_RDY);
  c_step_cont: cover property (meas_q == GRC_MEAS_STEP ##[1:20] meas_q == GRC_MEAS_RUN);
  c_app_err: cover property (app_hit);
  c_gen_run: cover property (gen_state[`GRC_RADIO] == GRC_GEN_RUN && rsp_q.valid);
endmodule
